/* File: hdl/scpc_pkg.sv */
/*
 * package for the sync and clock pin control block: register offsets,
 * field positions, reset values, timing counts and carrier structs.
 * assumes a single 25 mhz core clock and a plain register port.
 */
package scpc_pkg;
    // register offsets (byte addresses on the plain port)
    localparam logic [7:0] ADDR_CLK_CTRL    = 8'h03;
    localparam logic [7:0] ADDR_HS_POL      = 8'h12;
    localparam logic [7:0] ADDR_VS_CTRL     = 8'h14;
    localparam logic [7:0] ADDR_VS_WIDTH    = 8'h15;
    localparam logic [7:0] ADDR_HOLD_CTRL   = 8'h18;
    localparam logic [7:0] ADDR_HS_OUT_CTRL = 8'h19;
    localparam logic [7:0] ADDR_PWR_CTRL    = 8'h1e;
    localparam logic [7:0] ADDR_STATUS      = 8'h1f;
    // field positions
    localparam int EXT_CLK_SEL_BIT   = 2;
    localparam int HS_POL_LO         = 4;
    localparam int VS_PROG_WIDTH_BIT = 1;
    localparam int VS_INVERT_BIT     = 2;
    localparam int VS_SEPARATE_BIT   = 3;
    localparam int HOLD_POL_LO       = 6;
    localparam int PD_POL_BIT        = 2;
    localparam int PD_MANUAL_BIT     = 4;
    localparam int HS_OUT_POL_BIT    = 7;
    // reset values
    localparam logic [7:0] RST_CLK_CTRL    = 8'h00;
    localparam logic [7:0] RST_HS_POL      = 8'h00;
    localparam logic [7:0] RST_VS_CTRL     = 8'h00;
    localparam logic [7:0] RST_VS_WIDTH    = 8'h0a;
    localparam logic [7:0] RST_HOLD_CTRL   = 8'h40; // hold polarity field = 1
    localparam logic [7:0] RST_HS_OUT_CTRL = 8'h20;
    localparam logic [7:0] RST_PWR_CTRL    = 8'h04; // active-high pin
    // polarity field codes (2 bits: 0x = auto, 10 = low, 11 = high)
    localparam logic [1:0] POL_FIXED_HIGH  = 2'h3;
    // timing: address strap sampled after release of reset
    localparam int STRAP_SETTLE_NS = 1000;
    localparam int CLK_PERIOD_NS   = 40;
    localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // synchronised pin inputs
    typedef struct packed {
        logic hsync;
        logic vsync;
        logic csync;
        logic hold;
        logic pdn;
        logic strap;
    } scpc_pins_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } scpc_req_t;
endpackage

/* File: hdl/scpc_sync2.sv */
/*
 * two flip-flop synchroniser bank for pin inputs.
 * assumes every input bit is asynchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module scpc_sync2 #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/scpc_top.sv */
/*
 * sync and clock pin control: clock source select, clock hold, manual
 * power-down, regenerated hsync out, vsync out, address strap sampling.
 * assumes pins are asynchronous and pass the synchroniser, and a plain
 * register port with read data one cycle after the read strobe.
 */
// Notes on behaviour
// - external clock selected only when bit set
// - external clock and hold independent
// - hold freezes generator frequency and phase
// - hold sense automatic or from field
// - hold polarity resets to one
// - power-down pin honoured only in manual
// - power-down pin polarity from control bit
// - hsync output regenerated, clock aligned
// - hsync output polarity and width programmable
// - hsync output aligned with data clock
// - vsync output separated or passed through
// - vsync output polarity from control bit
// - vsync width from source or programmed
// - strap pin is address lsb
// - strap sampled once at power-up
// - vsync output released until strap sampled
// - generator locks to hsync leading edge
`timescale 1ns/1ps
`default_nettype none
module scpc_top
    import scpc_pkg::*;
#(
    parameter int VS_CNT_W = 8
) (
    input  wire logic              CORE_CLK,
    input  wire logic              RST,
    input  wire logic [7:0]        ADDR,
    input  wire logic [7:0]        WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output var  logic [7:0]        RDATA,
    input  wire logic              HSYNC_IN,
    input  wire logic              VSYNC_IN,
    input  wire logic              CSYNC_IN,
    input  wire logic              HOLD_EXT_CLK_PIN,
    input  wire logic              POWER_DOWN_PIN,
    input  wire logic              ADDRESS_LSB_STRAP_IN,
    output var  logic              EXTERNAL_SAMPLE_CLOCK_IN_SEL,
    output var  logic              GEN_HOLD,
    output var  logic              GEN_LOCK_PULSE,
    output var  logic              POWER_DOWN,
    output var  logic              REGENERATED_HSYNC_OUT,
    output var  logic              DATA_CLOCK_OUTPUT,
    output var  logic              VERTICAL_SYNC_OUT,
    output var  logic              VERTICAL_SYNC_OUT_OE_N,
    output var  logic              ADDRESS_LSB_STRAP
);
    import scpc_pkg::*;

    typedef enum logic [2:0] {
        ST_SETTLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_DRIVE  = 3'b100
    } scpc_pin_state_t;

    scpc_pins_t      pins;
    scpc_req_t       req;
    scpc_pin_state_t state;
    scpc_pin_state_t next_state;
    logic [7:0] clk_ctrl, hs_pol, vs_ctrl, vs_width, hold_ctrl, hs_out_ctrl, pwr_ctrl;
    logic [7:0] settle_cnt;
    logic [7:0] hs_cnt;
    logic [VS_CNT_W-1:0] vs_cnt;
    logic       hs_prev, vs_prev, data_clk;
    logic [11:0] hs_bal, hold_bal;
    logic       hs_auto_pol, hold_auto_pol;

    // pin synchronisers
    scpc_sync2 #(.WIDTH(6)) u_sync (
        .clk (CORE_CLK),
        .rst (RST),
        .d   ({HSYNC_IN, VSYNC_IN, CSYNC_IN, HOLD_EXT_CLK_PIN, POWER_DOWN_PIN, ADDRESS_LSB_STRAP_IN}),
        .q   (pins)
    );

    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // polarity and edge decode
    wire       hs_pol_man   = hs_pol[HS_POL_LO+1];
    wire       hs_pol_eff   = hs_pol_man ? hs_pol[HS_POL_LO] : hs_auto_pol;
    wire       hs_rise      = pins.hsync & ~hs_prev;
    wire       hs_fall      = ~pins.hsync & hs_prev;
    wire       hs_lead      = hs_pol_eff ? hs_rise : hs_fall;
    wire       hold_pol_man = hold_ctrl[HOLD_POL_LO+1];
    wire       hold_pol_eff = hold_pol_man ? hold_ctrl[HOLD_POL_LO] : hold_auto_pol;
    wire       hold_active  = (pins.hold == hold_pol_eff);
    wire       pd_active    = (pins.pdn == pwr_ctrl[PD_POL_BIT]);
    wire       vs_src       = vs_ctrl[VS_SEPARATE_BIT] ? pins.csync : pins.vsync;
    wire       vs_lead      = vs_src & ~vs_prev;
    wire       vs_prog      = vs_ctrl[VS_PROG_WIDTH_BIT];
    wire       vs_level     = vs_prog ? (vs_cnt != '0) : vs_src;
    wire [6:0] hs_width     = hs_out_ctrl[6:0];
    wire       hs_level     = (hs_cnt != 8'h00);

    // register read mux
    logic [7:0] rd_mux;
    always_comb begin
        case (req.addr)
            ADDR_CLK_CTRL:    rd_mux = clk_ctrl;
            ADDR_HS_POL:      rd_mux = hs_pol;
            ADDR_VS_CTRL:     rd_mux = vs_ctrl;
            ADDR_VS_WIDTH:    rd_mux = vs_width;
            ADDR_HOLD_CTRL:   rd_mux = hold_ctrl;
            ADDR_HS_OUT_CTRL: rd_mux = hs_out_ctrl;
            ADDR_PWR_CTRL:    rd_mux = pwr_ctrl;
            ADDR_STATUS:      rd_mux = {3'h0, ADDRESS_LSB_STRAP, hold_active, pd_active,
                                        hold_auto_pol, hs_auto_pol};
            default:          rd_mux = 8'h00;
        endcase
    end

    // register writes
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            clk_ctrl    <= RST_CLK_CTRL;
            hs_pol      <= RST_HS_POL;
            vs_ctrl     <= RST_VS_CTRL;
            vs_width    <= RST_VS_WIDTH;
            hold_ctrl   <= RST_HOLD_CTRL;
            hs_out_ctrl <= RST_HS_OUT_CTRL;
            pwr_ctrl    <= RST_PWR_CTRL;
        end else if (req.wr) begin
            case (req.addr)
                ADDR_CLK_CTRL:    clk_ctrl    <= req.wdata;
                ADDR_HS_POL:      hs_pol      <= req.wdata;
                ADDR_VS_CTRL:     vs_ctrl     <= req.wdata;
                ADDR_VS_WIDTH:    vs_width    <= req.wdata;
                ADDR_HOLD_CTRL:   hold_ctrl   <= req.wdata;
                ADDR_HS_OUT_CTRL: hs_out_ctrl <= req.wdata;
                ADDR_PWR_CTRL:    pwr_ctrl    <= req.wdata;
                default:          clk_ctrl    <= clk_ctrl;
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) RDATA <= 8'h00;
        else     RDATA <= req.rd ? rd_mux : 8'h00;
    end

    // automatic polarity: a saturating balance counter per pin leans toward
    // the level that is idle most of the time, and the active sense is the
    // other one; a lone pulse flips it only when it carries the count across bit 11, as near the reset midpoint
    wire       hs_bal_up    = pins.hsync & (hs_bal != 12'hfff);
    wire       hs_bal_dn    = ~pins.hsync & (hs_bal != 12'h000);
    wire       hold_bal_up  = pins.hold & (hold_bal != 12'hfff);
    wire       hold_bal_dn  = ~pins.hold & (hold_bal != 12'h000);
    assign hs_auto_pol   = ~hs_bal[11];
    assign hold_auto_pol = ~hold_bal[11];

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            hs_prev  <= 1'b0;
            vs_prev  <= 1'b0;
            hs_bal   <= 12'h7ff;                                          // midpoint, reads active high
            hold_bal <= 12'h7ff;
        end else begin
            hs_prev <= pins.hsync;
            vs_prev <= vs_src;
            if (hs_bal_up)        hs_bal <= hs_bal + 12'h001;
            else if (hs_bal_dn)   hs_bal <= hs_bal - 12'h001;
            if (hold_bal_up)      hold_bal <= hold_bal + 12'h001;
            else if (hold_bal_dn) hold_bal <= hold_bal - 12'h001;
        end
    end

    // clock source select from its own bit, generator control with the lock pulse gated by hold
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            EXTERNAL_SAMPLE_CLOCK_IN_SEL <= 1'b0;
            GEN_HOLD                     <= 1'b0;
            GEN_LOCK_PULSE               <= 1'b0;
            POWER_DOWN                   <= 1'b0;
        end else begin
            EXTERNAL_SAMPLE_CLOCK_IN_SEL <= clk_ctrl[EXT_CLK_SEL_BIT];
            GEN_HOLD                     <= hold_active;
            GEN_LOCK_PULSE               <= hs_lead & ~hold_active;
            POWER_DOWN                   <= pwr_ctrl[PD_MANUAL_BIT] & pd_active;
        end
    end

    // data clock and regenerated hsync share one pipeline stage
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            data_clk              <= 1'b0;
            hs_cnt                <= 8'h00;
            DATA_CLOCK_OUTPUT     <= 1'b0;
            REGENERATED_HSYNC_OUT <= 1'b0;
        end else begin
            data_clk <= ~data_clk;
            if (hs_lead)        hs_cnt <= {1'b0, hs_width};
            else if (hs_level)  hs_cnt <= hs_cnt - 8'h01;
            DATA_CLOCK_OUTPUT     <= data_clk;
            REGENERATED_HSYNC_OUT <= hs_level ^ ~hs_out_ctrl[HS_OUT_POL_BIT];
        end
    end

    // vsync output width counter and polarity
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            vs_cnt            <= '0;
            VERTICAL_SYNC_OUT <= 1'b0;
        end else begin
            if (vs_lead)           vs_cnt <= VS_CNT_W'(vs_width);
            else if (vs_cnt != '0) vs_cnt <= vs_cnt - 1'b1;
            VERTICAL_SYNC_OUT <= vs_level ^ vs_ctrl[VS_INVERT_BIT];
        end
    end

    // strap sequencer: release the shared pin, settle, sample, then drive
    always_comb begin
        case (state)
            ST_SETTLE: next_state = (settle_cnt == 8'(STRAP_SETTLE_CYC)) ? ST_SAMPLE : ST_SETTLE;
            ST_SAMPLE: next_state = ST_DRIVE;
            ST_DRIVE:  next_state = ST_DRIVE;
            default:   next_state = ST_SETTLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state                  <= ST_SETTLE;
            settle_cnt             <= 8'h00;
            ADDRESS_LSB_STRAP      <= 1'b0;
            VERTICAL_SYNC_OUT_OE_N <= 1'b1;
        end else begin
            state <= next_state;
            if (state == ST_SETTLE) settle_cnt <= settle_cnt + 8'h01;
            if (state == ST_SAMPLE) ADDRESS_LSB_STRAP <= pins.strap;
            VERTICAL_SYNC_OUT_OE_N <= (next_state != ST_DRIVE);
        end
    end

    // checks
    property p_ext_sel;
        @(posedge CORE_CLK) disable iff (RST)
        1'b1 |=> EXTERNAL_SAMPLE_CLOCK_IN_SEL == $past(clk_ctrl[EXT_CLK_SEL_BIT]);
    endproperty
    a_ext_sel: assert property (p_ext_sel) else $error("clock select wrong");

    property p_hold_no_lock;
        @(posedge CORE_CLK) disable iff (RST)
        hold_active |=> !GEN_LOCK_PULSE;
    endproperty
    a_hold_no_lock: assert property (p_hold_no_lock) else $error("lock while holding");

    property p_hold_rst_pol;
        @(posedge CORE_CLK) $rose(!RST) |-> hold_ctrl[7:6] == 2'h1;
    endproperty
    a_hold_rst_pol: assert property (p_hold_rst_pol) else $error("hold polarity reset");

    property p_pd_auto;
        @(posedge CORE_CLK) disable iff (RST)
        !pwr_ctrl[PD_MANUAL_BIT] |=> !POWER_DOWN;
    endproperty
    a_pd_auto: assert property (p_pd_auto) else $error("pin honoured in auto");

    property p_pd_pol;
        @(posedge CORE_CLK) disable iff (RST)
        pwr_ctrl[PD_MANUAL_BIT] && pins.pdn == pwr_ctrl[PD_POL_BIT] |=> POWER_DOWN;
    endproperty
    a_pd_pol: assert property (p_pd_pol) else $error("power-down polarity");

    sequence s_hs_start;
        hs_lead && hs_width > 7'h1;
    endsequence
    property p_hs_width;
        @(posedge CORE_CLK) disable iff (RST)
        s_hs_start ##1 !hs_lead |=> hs_level;
    endproperty
    a_hs_width: assert property (p_hs_width) else $error("hsync pulse too short");

    property p_lock_edge;
        @(posedge CORE_CLK) disable iff (RST)
        GEN_LOCK_PULSE |-> $past(hs_pol_eff) ? $past(pins.hsync) : !$past(pins.hsync);
    endproperty
    a_lock_edge: assert property (p_lock_edge) else $error("lock on wrong edge");

    property p_strap_hold;
        @(posedge CORE_CLK) disable iff (RST)
        state == ST_DRIVE ##1 state == ST_DRIVE |-> $stable(ADDRESS_LSB_STRAP);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed later");

    property p_oe_drive;
        @(posedge CORE_CLK) disable iff (RST)
        state != ST_DRIVE |-> VERTICAL_SYNC_OUT_OE_N;
    endproperty
    a_oe_drive: assert property (p_oe_drive) else $error("pin driven during strap");

    property p_hs_idle;
        @(posedge CORE_CLK) disable iff (RST)
        !hs_level |=> REGENERATED_HSYNC_OUT == !$past(hs_out_ctrl[HS_OUT_POL_BIT]);
    endproperty
    a_hs_idle: assert property (p_hs_idle) else $error("hsync idle level wrong");

    property p_vs_prog;
        @(posedge CORE_CLK) disable iff (RST)
        vs_lead && vs_prog && vs_width != 8'h00 |=> !vs_prog || vs_level;
    endproperty
    a_vs_prog: assert property (p_vs_prog) else $error("programmed vsync missing");
endmodule
`default_nettype wire

/* File: verif/scpc_src_model.sv */
/*
 * source model: a graphics source driving hsync, vsync and csync.
 * assumes the bench asks for one pulse at a time and sets the level first.
 */
`timescale 1ns/1ps
`default_nettype none
module scpc_src_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [1:0] sel,
    input  wire logic       act,
    input  wire logic [7:0] len,
    output wire logic       hsync,
    output wire logic       vsync,
    output wire logic       csync
);
    logic [7:0] cnt  = 8'h00;
    logic [1:0] line = 2'h0;
    // one pulse of len cycles on the chosen line
    always_ff @(posedge clk) begin
        if (go && cnt == 8'h00) begin
            cnt  <= len;
            line <= sel;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end
    // lines rest at the inverse of the pulse level
    assign hsync = (cnt != 8'h00 && line == 2'h0) ? act : ~act;
    assign vsync = (cnt != 8'h00 && line == 2'h1) ? act : ~act;
    assign csync = (cnt != 8'h00 && line == 2'h2) ? act : ~act;
endmodule
`default_nettype wire

/* File: verif/scpc_top_bench.sv */
/*
 * self-checking bench for scpc_top: registers, pins and sync outputs.
 * assumes scpc_src_model drives the sync inputs and a 25 mhz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module scpc_top_bench;
    import scpc_pkg::*;
    logic       CORE_CLK = 1'b0;
    logic       RST = 1'b1;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
    logic       WR = 1'b0, RD = 1'b0, HOLD = 1'b0, PD_PIN = 1'b0, STRAP = 1'b0;
    wire logic  hs, vs, cs;
    logic       SEL, GHOLD, LOCK, PD, HSO, DCK, VSO, OE_N, STRAP_Q;
    logic       go = 1'b0, a_lvl = 1'b1;
    logic [1:0] sel = 2'h0;
    logic [7:0] slen = 8'h00, v;
    int         err_total = 0, cmp_count = 0, lock_n = 0, cyc = 0, n, w, ln;
    logic [7:0] ra [7] = '{8'h03, 8'h18, 8'h1e, 8'h19, 8'h15, 8'h14, 8'h40};
    logic [7:0] re [7] = '{RST_CLK_CTRL, RST_HOLD_CTRL, RST_PWR_CTRL, RST_HS_OUT_CTRL,
                           RST_VS_WIDTH, RST_VS_CTRL, 8'h00};
    logic [7:0] vc [4] = '{8'h00, 8'h04, 8'h08, 8'h02};
    wire logic  obs = (sel == 2'h0) ? HSO : VSO;

    scpc_top scpc_top_i (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .HSYNC_IN(hs), .VSYNC_IN(vs), .CSYNC_IN(cs),
        .HOLD_EXT_CLK_PIN(HOLD), .POWER_DOWN_PIN(PD_PIN), .ADDRESS_LSB_STRAP_IN(STRAP),
        .EXTERNAL_SAMPLE_CLOCK_IN_SEL(SEL), .GEN_HOLD(GHOLD), .GEN_LOCK_PULSE(LOCK),
        .POWER_DOWN(PD), .REGENERATED_HSYNC_OUT(HSO), .DATA_CLOCK_OUTPUT(DCK),
        .VERTICAL_SYNC_OUT(VSO), .VERTICAL_SYNC_OUT_OE_N(OE_N), .ADDRESS_LSB_STRAP(STRAP_Q));
    scpc_src_model scpc_src_model_i (.clk(CORE_CLK), .go(go), .sel(sel), .act(a_lvl),
        .len(slen), .hsync(hs), .vsync(vs), .csync(cs));

    // clock, lock pulse counter and hang guard
    always #20 CORE_CLK = ~CORE_CLK;
    always @(negedge CORE_CLK) if (LOCK === 1'b1) lock_n++;
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_n(input int g, input int e);
        cmp_count++;
        if (g != e) begin
            err_total++;
            $display("Error at %0t: count %0d expected %0d", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        ADDR <= a; WDATA <= d; WR <= 1'b1;
        @(posedge CORE_CLK) WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CORE_CLK);
        ADDR <= a; RD <= 1'b1;
        @(posedge CORE_CLK) RD <= 1'b0;
        #1 d = RDATA;
    endtask
    // settle the line level, send one pulse, count active output cycles
    task automatic pulse(input logic [1:0] s, input logic a, input int len, input logic o,
                         output int c);
        @(posedge CORE_CLK) a_lvl <= a;
        sel <= s;
        repeat (60) @(posedge CORE_CLK);
        lock_n = 0;
        c = 0;
        slen <= len[7:0];
        go <= 1'b1;
        @(posedge CORE_CLK) go <= 1'b0;
        repeat (len + 30) begin
            @(posedge CORE_CLK);
            #1 if (obs === o) c++;
        end
    endtask

    initial begin
        void'($urandom(58));
        STRAP <= 1'($urandom);
        repeat (6) @(posedge CORE_CLK);
        RST <= 1'b0;
        repeat (30) @(posedge CORE_CLK);
        #1 chk(STRAP_Q, STRAP);
        chk(OE_N, 8'h00);
        @(posedge CORE_CLK) STRAP <= ~STRAP;
        repeat (6) @(posedge CORE_CLK);
        rd(ADDR_STATUS, v);
        chk(v[4], {7'h00, ~STRAP});
        for (int i = 0; i < 7; i++) begin
            rd(ra[i], v);
            chk(v, re[i]);
        end
        @(posedge CORE_CLK) #1 v[0] = DCK;
        @(posedge CORE_CLK) #1 chk(DCK, {7'h00, ~v[0]});
        // clock source select, with the shared pin moving meanwhile
        for (int i = 0; i < 8; i++) begin
            w = $urandom;
            @(posedge CORE_CLK) HOLD <= 1'($urandom);
            wr(ADDR_CLK_CTRL, w[7:0]);
            rd(ADDR_CLK_CTRL, v);
            chk(v[2], w[2]);
            chk(SEL, w[2]);
        end
        // manual hold polarity against pin level
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_HOLD_CTRL, {1'b1, i[0], 6'h00});
            @(posedge CORE_CLK) HOLD <= i[1];
            repeat (6) @(posedge CORE_CLK);
            #1 chk(GHOLD, i[0] == i[1]);
            chk(SEL, w[2]);
        end
        pulse(2'h0, 1'b1, 20, 1'b1, n);
        chk_n(lock_n, 0);
        wr(ADDR_HOLD_CTRL, 8'hc0);
        @(posedge CORE_CLK) HOLD <= 1'b0;
        repeat (6) @(posedge CORE_CLK);
        #1 chk(GHOLD, 8'h00);
        // hsync out width and polarity, lock on the leading edge only
        for (int p = 0; p < 2; p++) begin
            w = 2 + $urandom % 30;
            wr(ADDR_HS_POL, {2'h0, 1'b1, p[0], 4'h0});
            wr(ADDR_HS_OUT_CTRL, {p[0], w[6:0]});
            pulse(2'h0, p[0], 50, p[0], n);
            chk_n(n, w);
            chk_n(lock_n, 1);
        end
        // vsync out: pass, invert, separated, programmed width
        for (int k = 0; k < 4; k++) begin
            ln = 10 + $urandom % 40;
            w = 2 + $urandom % 8;
            wr(ADDR_VS_WIDTH, w[7:0]);
            wr(ADDR_VS_CTRL, vc[k]);
            pulse((k == 2) ? 2'h2 : 2'h1, 1'b1, ln, k != 1, n);
            chk_n(n, (k == 3) ? w : ln);
        end
        // power-down pin against manual select and polarity
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_PWR_CTRL, {3'h0, i[2], 1'b0, i[1], 2'h0});
            @(posedge CORE_CLK) PD_PIN <= i[0];
            repeat (6) @(posedge CORE_CLK);
            #1 chk(PD, i[2] & (i[1] == i[0]));
        end
        wr(ADDR_PWR_CTRL, 8'h14);
        @(posedge CORE_CLK) PD_PIN <= 1'b0;
        repeat (6) @(posedge CORE_CLK);
        #1 chk(PD, 8'h00);
        // automatic senses: hold pin and hsync idled low, so both read active high
        wr(ADDR_HOLD_CTRL, RST_HOLD_CTRL);
        repeat (6) @(posedge CORE_CLK);
        #1 chk(GHOLD, 8'h00);
        wr(ADDR_HS_POL, 8'h00);
        pulse(2'h0, 1'b1, 20, 1'b1, n);
        chk_n(lock_n, 1);
        give_verdict();
    end
endmodule
`default_nettype wire
